// ==== core/ipfs_fault_class.sv ====
module ipfs_fault_class
(
  input  wire ipfs_pkg::ipfs_fault_t fault,
  input  wire logic                  status_nonzero,
  output logic [3:0]                 set_bits,
  output logic                       second_fault
);

  // Classify one faulting access into fault status bits
  always_comb
  begin
    set_bits     = 4'h0;
    second_fault = 1'b0;
    if (fault.valid)
    begin
      // Narrow peripheral access or misaligned word
      set_bits[ipfs_pkg::AFSR_BAD_WIDTH] =
        (fault.apb_target && (fault.size == ipfs_pkg::SIZE_BYTE ||
                              fault.size == ipfs_pkg::SIZE_HALF)) ||
        (fault.size == ipfs_pkg::SIZE_WORD && fault.addr_lo != 2'h0);
      set_bits[ipfs_pkg::AFSR_PRIV] =
        fault.unpriv_write && fault.protected_target;
      set_bits[ipfs_pkg::AFSR_UNMAPPED] =
        (fault.apb_target && fault.above_last_reg) ||
        fault.above_memory;
      // Fault on top of a recorded one
      set_bits[ipfs_pkg::AFSR_SECOND] = status_nonzero;
      second_fault = status_nonzero;
    end
  end

endmodule

// ==== core/ipfs_pkg.sv ====
package ipfs_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_MISSED     = 32'h4000A820;
  localparam logic [31:0] ADDR_PEND_SET   = 32'hE000E200;
  localparam logic [31:0] ADDR_PEND_CLEAR = 32'hE000E280;
  localparam logic [31:0] ADDR_ACTIVE     = 32'hE000E300;
  localparam logic [31:0] ADDR_AFSR       = 32'hE000ED3C;

  // Source bit positions, shared by every top-level register
  localparam int BIT_DEBUG        = 16;
  localparam int BIT_EXT_LINE_D   = 15;
  localparam int BIT_EXT_LINE_C   = 14;
  localparam int BIT_EXT_LINE_A   = 12;
  localparam int BIT_RADIO_RX     = 10;
  localparam int BIT_RADIO_TX     = 9;
  localparam int BIT_RADIO_TIMER  = 8;
  localparam int BIT_CRYPTO       = 7;
  localparam int BIT_SERIAL_ONE   = 5;
  localparam int BIT_SLEEP_TIMER  = 4;
  localparam int BIT_BASEBAND     = 3;
  localparam int BIT_MANAGEMENT   = 2;

  // Implemented source bits; missed register has no debug flag
  localparam logic [31:0] SRC_MASK  = 32'h0001D7BC;
  localparam logic [31:0] MISS_MASK = 32'h0000D7BC;

  // Fault status field positions
  localparam int AFSR_BAD_WIDTH = 3;
  localparam int AFSR_PRIV      = 2;
  localparam int AFSR_UNMAPPED  = 1;
  localparam int AFSR_SECOND    = 0;
  localparam logic [31:0] AFSR_MASK = 32'h0000000F;

  // Access sizes of a faulting transfer
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Description of one faulting bus access
  typedef struct packed {
    logic       valid;
    logic [1:0] size;
    logic [1:0] addr_lo;
    logic       apb_target;
    logic       unpriv_write;
    logic       protected_target;
    logic       above_last_reg;
    logic       above_memory;
  } ipfs_fault_t;

  // Whole state of the top module
  typedef struct packed {
    logic [31:0] pend;
    logic [31:0] active;
    logic [31:0] missed;
    logic [31:0] afsr;
    logic        awready;
    logic        wready;
    logic        aw_have;
    logic        w_have;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        hard_fault;
  } ipfs_state_t;

  localparam ipfs_state_t STATE_RESET = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                          default: '0};

endpackage

// ==== core/ipfs_top.sv ====
// Summary of operation
// - Every source keeps one fixed bit position across all top-level registers.
// - Writing 1 to a pend-set bit makes that source pending.
// - Writing 0 to a pend-set bit leaves pending state alone.
// - Writing 1 to a pend-clear bit removes that source's pending state.
// - Writing 0 to a pend-clear bit leaves pending state alone.
// - Active register is read-only; a bit reads 1 while its source is active.
// - Missed flag sets when a source's interrupt is missed; software may read and write.
// - Missed bits 31..16 and 1..0 read zero; flags at shared positions.
// - Byte or halfword access to a peripheral register sets the bad-width fault.
// - A misaligned word access also sets the bad-width fault.
// - Unprivileged write to system peripheral or protected RAM sets privilege fault.
// - Access above last register inside a peripheral block sets unmapped fault.
// - Access beyond top of RAM or flash also sets unmapped fault.
// - A fault while any status bit is already set sets the second-fault bit.
// - Pending, active, missed and fault status all reset to zero.
// - A second fault also raises a hard fault that preempts the bus fault.
//
// Implementation choice: register access over AXI4-Lite.
module ipfs_top
#(
  parameter int ADDR_W = 32
)
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [31:0]           src_event,
  input  wire logic [31:0]           core_ack,
  input  wire logic [31:0]           core_exit,
  input  wire ipfs_pkg::ipfs_fault_t bus_fault,
  output logic [31:0]                pending_out,
  output logic [31:0]                active_out,
  output logic [31:0]                missed_out,
  output logic [31:0]                fault_status_out,
  output logic                       hard_fault
);

  // Refuse address widths that cannot reach the register map
  if (ADDR_W != 32)
  begin : g_bad_width
    $error("ipfs_top needs ADDR_W of 32");
  end

  ipfs_pkg::ipfs_state_t st_reg;
  ipfs_pkg::ipfs_state_t st_next;
  logic [31:0]           hw_set;
  logic [31:0]           ack_set;
  logic [31:0]           exit_clr;
  logic [31:0]           sw_set;
  logic [31:0]           sw_clr;
  logic [31:0]           miss_set;
  logic [31:0]           wmask;
  logic                  miss_wr;
  logic                  afsr_wr;
  logic                  active_wr;
  logic [3:0]            fault_set;
  logic                  fault_second;
  logic [32:0]           rd_word;

  // Word-address comparison against a register byte address
  function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] reg_addr);
    addr_hit = (addr[31:2] == reg_addr[31:2]);
  endfunction

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Strobed merge of write data into a stored value
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // Read decode: hit flag above the data word
  function automatic logic [32:0] reg_read(input logic [31:0] addr,
                                           input ipfs_pkg::ipfs_state_t s);
    if (addr_hit(addr, ipfs_pkg::ADDR_PEND_SET) || addr_hit(addr, ipfs_pkg::ADDR_PEND_CLEAR))
      reg_read = {1'b1, s.pend};
    else if (addr_hit(addr, ipfs_pkg::ADDR_ACTIVE))
      reg_read = {1'b1, s.active};
    else if (addr_hit(addr, ipfs_pkg::ADDR_MISSED))
      reg_read = {1'b1, s.missed & ipfs_pkg::MISS_MASK};
    else if (addr_hit(addr, ipfs_pkg::ADDR_AFSR))
      reg_read = {1'b1, s.afsr & ipfs_pkg::AFSR_MASK};
    else
      reg_read = {1'b0, 32'h00000000};
  endfunction

  // Fault classification
  ipfs_fault_class u_fault_class
  (
    .fault          (bus_fault),
    .status_nonzero (st_reg.afsr != 32'h00000000),
    .set_bits       (fault_set),
    .second_fault   (fault_second)
  );

  // Next state: bus slave, pending, active, missed and fault status
  always_comb
  begin
    st_next   = st_reg;
    hw_set    = src_event & ipfs_pkg::SRC_MASK;
    ack_set   = core_ack & ipfs_pkg::SRC_MASK;
    exit_clr  = core_exit & ipfs_pkg::SRC_MASK;
    sw_set    = 32'h00000000;
    sw_clr    = 32'h00000000;
    miss_wr   = 1'b0;
    afsr_wr   = 1'b0;
    active_wr = 1'b0;
    wmask     = strb_mask(st_reg.wstrb);
    rd_word   = reg_read(s_axi_araddr, st_reg);
    // Write address and data channels, taken in either order
    if (s_axi_awvalid && st_reg.awready)
    begin
      st_next.awaddr  = s_axi_awaddr;
      st_next.aw_have = 1'b1;
      st_next.awready = 1'b0;
    end
    if (s_axi_wvalid && st_reg.wready)
    begin
      st_next.wdata  = s_axi_wdata;
      st_next.wstrb  = s_axi_wstrb;
      st_next.w_have = 1'b1;
      st_next.wready = 1'b0;
    end
    // Perform the write once both halves are held
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid)
    begin
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = ipfs_pkg::RESP_OKAY;
      if (addr_hit(st_reg.awaddr, ipfs_pkg::ADDR_PEND_SET))
        sw_set = st_reg.wdata & wmask & ipfs_pkg::SRC_MASK;
      else if (addr_hit(st_reg.awaddr, ipfs_pkg::ADDR_PEND_CLEAR))
        sw_clr = st_reg.wdata & wmask & ipfs_pkg::SRC_MASK;
      else if (addr_hit(st_reg.awaddr, ipfs_pkg::ADDR_ACTIVE))
        active_wr = 1'b1;
      else if (addr_hit(st_reg.awaddr, ipfs_pkg::ADDR_MISSED))
        miss_wr = 1'b1;
      else if (addr_hit(st_reg.awaddr, ipfs_pkg::ADDR_AFSR))
        afsr_wr = 1'b1;
      else
        st_next.bresp = ipfs_pkg::RESP_SLVERR;
    end
    // Response accepted, reopen both write channels
    if (st_reg.bvalid && s_axi_bready)
    begin
      st_next.bvalid  = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready  = 1'b1;
    end
    // Read channel: data captured with the address
    if (s_axi_arvalid && st_reg.arready)
    begin
      st_next.arready = 1'b0;
      st_next.rvalid  = 1'b1;
      st_next.rdata   = rd_word[31:0];
      st_next.rresp   = rd_word[32] ? ipfs_pkg::RESP_OKAY : ipfs_pkg::RESP_SLVERR;
    end
    if (st_reg.rvalid && s_axi_rready)
    begin
      st_next.rvalid  = 1'b0;
      st_next.arready = 1'b1;
    end
    // Pending: new events win over clears and core acceptance
    st_next.pend = ((st_reg.pend & ~(sw_clr | ack_set)) | hw_set | sw_set) &
                   ipfs_pkg::SRC_MASK;
    // Active: entry wins over exit in the same cycle
    st_next.active = ((st_reg.active & ~exit_clr) | ack_set) & ipfs_pkg::SRC_MASK;
    // Missed: event on a source that is still pending
    miss_set = hw_set & st_reg.pend & ipfs_pkg::MISS_MASK;
    st_next.missed = ((miss_wr ? merge(st_reg.missed, st_reg.wdata, wmask) : st_reg.missed)
                      | miss_set) & ipfs_pkg::MISS_MASK;
    // Fault status: hardware set wins over software write
    st_next.afsr = ((afsr_wr ? merge(st_reg.afsr, st_reg.wdata, wmask) : st_reg.afsr)
                    | {28'h0000000, fault_set}) & ipfs_pkg::AFSR_MASK;
    st_next.hard_fault = fault_second;
  end

  // State register, frozen while ce is low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_reg <= ipfs_pkg::STATE_RESET;
    else if (ce)
      st_reg <= st_next;
  end

  // Outputs straight from the state register
  assign s_axi_awready    = st_reg.awready;
  assign s_axi_wready     = st_reg.wready;
  assign s_axi_bvalid     = st_reg.bvalid;
  assign s_axi_bresp      = st_reg.bresp;
  assign s_axi_arready    = st_reg.arready;
  assign s_axi_rvalid     = st_reg.rvalid;
  assign s_axi_rdata      = st_reg.rdata;
  assign s_axi_rresp      = st_reg.rresp;
  assign pending_out      = st_reg.pend;
  assign active_out       = st_reg.active;
  assign missed_out       = st_reg.missed;
  assign fault_status_out = st_reg.afsr;
  assign hard_fault       = st_reg.hard_fault;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Steps of a recorded fault and of a register read
  sequence s_fault_taken;
    ce && bus_fault.valid;
  endsequence

  sequence s_second_seen;
    fault_status_out[ipfs_pkg::AFSR_SECOND] && hard_fault;
  endsequence

  sequence s_read_taken;
    ce && s_axi_arvalid && s_axi_arready;
  endsequence

  chk_pend_set_one: assert property ((ce && sw_set != 32'h00000000) |=>
    ((pending_out & $past(sw_set)) == $past(sw_set)))
    else $error("pend-set write did not make sources pending");

  chk_pend_zero_keep: assert property ((ce && sw_set == 32'h00000000 &&
    ack_set == 32'h0 && sw_clr == 32'h0 && hw_set == 32'h0) |=>
    (pending_out == $past(pending_out)))
    else $error("pending changed without any cause");

  chk_pend_clear_one: assert property ((ce && (sw_clr & ~hw_set & ~sw_set) != 32'h0) |=>
    ((pending_out & $past(sw_clr & ~hw_set & ~sw_set)) == 32'h0))
    else $error("pend-clear write left sources pending");

  chk_active_ro: assert property ((ce && active_wr && ack_set == 32'h0 &&
    exit_clr == 32'h0) |=> (active_out == $past(active_out)))
    else $error("write changed the active register");

  chk_miss_flag: assert property ((ce && miss_set != 32'h0) |=>
    ((missed_out & $past(miss_set)) == $past(miss_set)))
    else $error("missed event not flagged");

  chk_miss_reserved: assert property ((missed_out & ~ipfs_pkg::MISS_MASK) == 32'h0)
    else $error("missed register reserved bits set");

  chk_fault_width: assert property ((s_fault_taken and ##0
    ((bus_fault.apb_target && (bus_fault.size == ipfs_pkg::SIZE_BYTE ||
    bus_fault.size == ipfs_pkg::SIZE_HALF)) || (bus_fault.size == ipfs_pkg::SIZE_WORD &&
    bus_fault.addr_lo != 2'h0))) |=> fault_status_out[ipfs_pkg::AFSR_BAD_WIDTH])
    else $error("bad width fault not recorded");

  chk_fault_priv: assert property ((s_fault_taken and ##0
    (bus_fault.unpriv_write && bus_fault.protected_target)) |=>
    fault_status_out[ipfs_pkg::AFSR_PRIV])
    else $error("privilege fault not recorded");

  chk_fault_unmapped: assert property ((s_fault_taken and ##0
    ((bus_fault.apb_target && bus_fault.above_last_reg) || bus_fault.above_memory)) |=>
    fault_status_out[ipfs_pkg::AFSR_UNMAPPED])
    else $error("unmapped fault not recorded");

  chk_second_fault: assert property ((s_fault_taken and ##0
    (fault_status_out != 32'h0)) |=> s_second_seen)
    else $error("second fault or hard fault missing");

  chk_hard_pulse: assert property ((ce && !(bus_fault.valid &&
    fault_status_out != 32'h0)) |=> !hard_fault)
    else $error("hard fault lasted beyond its fault");

  chk_reset_zero: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
    (pending_out == 32'h0 && active_out == 32'h0 && missed_out == 32'h0 &&
     fault_status_out == 32'h0 && !hard_fault))
    else $error("status not zero after reset");

  chk_read_pend: assert property ((s_read_taken and ##0
    (addr_hit(s_axi_araddr, ipfs_pkg::ADDR_PEND_SET) ||
    addr_hit(s_axi_araddr, ipfs_pkg::ADDR_PEND_CLEAR))) |=>
    (s_axi_rvalid && s_axi_rdata == $past(pending_out)))
    else $error("pend read did not return pending state");

  chk_read_active: assert property ((s_read_taken and ##0
    addr_hit(s_axi_araddr, ipfs_pkg::ADDR_ACTIVE)) |=>
    (s_axi_rvalid && s_axi_rdata == $past(active_out)))
    else $error("active read did not return active state");

  chk_read_missed: assert property ((s_read_taken and ##0
    addr_hit(s_axi_araddr, ipfs_pkg::ADDR_MISSED)) |=>
    (s_axi_rdata == ($past(missed_out) & ipfs_pkg::MISS_MASK)))
    else $error("missed read returned reserved bits");

endmodule

// ==== verification/ipfs_core_model.sv ====
module ipfs_core_model
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        take_en,
  input  wire logic        slow,
  input  wire logic [31:0] pending,
  output logic      [31:0] core_ack,
  output logic      [31:0] core_exit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] held;
  logic [3:0]  stay;
  logic        busy;

  // Take the lowest pending source, stay in its handler, then leave it
  always @(posedge aclk)
  begin
    core_ack  <= 32'h0;
    core_exit <= 32'h0;
    if (!aresetn)
    begin
      busy <= 1'b0;
      held <= 32'h0;
      stay <= 4'h0;
    end
    else if (!busy && take_en && (pending != 32'h0))
    begin
      held     <= pending & (~pending + 32'h1);
      core_ack <= pending & (~pending + 32'h1);
      stay     <= slow ? 4'hF : 4'h1; // Long stay keeps the source active for reads
      busy     <= 1'b1;
    end
    else if (busy && (stay == 4'h0))
    begin
      core_exit <= held;
      busy      <= 1'b0;
    end
    else if (busy)
    begin
      stay <= stay - 4'h1;
    end
  end
endmodule

// ==== verification/ipfs_top_test.sv ====
module ipfs_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  aclk, aresetn, ce, take_en, slow, hard_fault;
  logic                  s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0]           s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, src_event;
  logic [31:0]           core_ack, core_exit, pending_out, active_out, missed_out;
  logic [31:0]           fault_status_out, p, r, c, m;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic [33:0]           e;
  logic [33:0]           exp_q [$];
  ipfs_pkg::ipfs_fault_t bus_fault;
  int                    fails, tests_run, cyc, n;

  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  ipfs_top dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .src_event, .core_ack, .core_exit, .bus_fault, .pending_out,
    .active_out, .missed_out, .fault_status_out, .hard_fault);
  ipfs_core_model core (.aclk, .aresetn, .take_en, .slow, .pending(pending_out), .core_ack,
    .core_exit);

  task automatic final_report();
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if ((fails == 0) && (tests_run > 0))
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      tests_run++;
      if (seen !== exp)
      begin
        fails++;
        $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Write one word and compare the response code
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    begin
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      forever
      begin
        @(posedge aclk);
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid)
          break;
      end
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, er});
    end
  endtask

  // Read one word; the expected answer is queued for the monitor
  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    begin
      @(posedge aclk);
      exp_q.push_back({er, d});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      forever
      begin
        @(posedge aclk);
        if (s_axi_arready)
          s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid)
          break;
      end
      s_axi_rready <= 1'b0;
    end
  endtask

  // Read answers are compared against the oldest note
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready && (exp_q.size() > 0))
    begin
      e = exp_q.pop_front();
      check(s_axi_rdata, e[31:0]);
      check({30'h0, s_axi_rresp}, {30'h0, e[33:32]});
    end
  end

  // Hang guard
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails++;
      final_report();
    end
  end

  function automatic ipfs_pkg::ipfs_fault_t mkf(input logic [1:0] sz, input logic [1:0] lo,
                                                 input logic [4:0] fl);
    return {1'b1, sz, lo, fl};
  endfunction

  // One fault cycle on the fault input
  task automatic inject(input ipfs_pkg::ipfs_fault_t f);
    begin
      @(posedge aclk);
      bus_fault <= f;
      @(posedge aclk);
      bus_fault <= '0;
      #1;
    end
  endtask

  // A first fault classifies; a repeat flags the second fault and a hard fault pulse
  task automatic fault_case(input ipfs_pkg::ipfs_fault_t f, input logic [31:0] ex);
    begin
      wr(ipfs_pkg::ADDR_AFSR, 32'h0, ipfs_pkg::RESP_OKAY);
      inject(f);
      check(fault_status_out, ex);
      check({31'h0, hard_fault}, 32'h0);
      inject(f);
      check(fault_status_out, ex | 32'h1);
      check({31'h0, hard_fault}, 32'h1);
      @(posedge aclk);
      #1;
      check({31'h0, hard_fault}, 32'h0);
    end
  endtask

  // Wait a bounded time for the active state to reach a value
  task automatic wait_active(input logic [31:0] v);
    begin
      n = 0;
      while ((active_out !== v) && (n < 40))
      begin
        @(posedge aclk);
        n++;
      end
      check(active_out, v);
    end
  endtask

  initial
  begin
    {aresetn, take_en, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr, src_event} = '0;
    {fails, tests_run, cyc} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    bus_fault = '0;
    r = $urandom(21215);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ipfs_pkg::ADDR_PEND_SET, 32'h0, ipfs_pkg::RESP_OKAY);
    rd(ipfs_pkg::ADDR_PEND_CLEAR, 32'h0, ipfs_pkg::RESP_OKAY);
    rd(ipfs_pkg::ADDR_ACTIVE, 32'h0, ipfs_pkg::RESP_OKAY);
    rd(ipfs_pkg::ADDR_MISSED, 32'h0, ipfs_pkg::RESP_OKAY);
    rd(ipfs_pkg::ADDR_AFSR, 32'h0, ipfs_pkg::RESP_OKAY);
    rd(32'hE000E204, 32'h0, ipfs_pkg::RESP_SLVERR);
    // Random set and clear patterns, zero writes and read-back
    p = 32'h0;
    repeat (4)
    begin
      r = $urandom;
      c = $urandom;
      wr(ipfs_pkg::ADDR_PEND_SET, r, ipfs_pkg::RESP_OKAY);
      p = p | (r & 32'h0001D7BC);
      check(pending_out, p);
      wr(ipfs_pkg::ADDR_PEND_SET, 32'h0, ipfs_pkg::RESP_OKAY);
      check(pending_out, p);
      rd(ipfs_pkg::ADDR_PEND_SET, p, ipfs_pkg::RESP_OKAY);
      wr(ipfs_pkg::ADDR_PEND_CLEAR, c, ipfs_pkg::RESP_OKAY);
      p = p & ~c;
      check(pending_out, p);
      wr(ipfs_pkg::ADDR_PEND_CLEAR, 32'h0, ipfs_pkg::RESP_OKAY);
      check(pending_out, p);
      rd(ipfs_pkg::ADDR_PEND_CLEAR, p, ipfs_pkg::RESP_OKAY);
    end
    wr(32'hE000E204, 32'hFFFFFFFF, ipfs_pkg::RESP_SLVERR);
    check(pending_out, p);
    wr(ipfs_pkg::ADDR_PEND_CLEAR, 32'hFFFFFFFF, ipfs_pkg::RESP_OKAY);
    // Clock enable low freezes pending state against source events
    @(posedge aclk);
    ce        <= 1'b0;
    src_event <= 32'h00000004;
    repeat (2) @(posedge aclk);
    src_event <= '0;
    ce        <= 1'b1;
    #1;
    check(pending_out, 32'h0);
    // Each source pends, then a repeat event while pending is missed on all but the debug source
    for (int b = 0; b < 32; b++)
    begin
      if (ipfs_pkg::SRC_MASK[b])
      begin
        m = 32'h1 << b;
        @(posedge aclk);
        src_event <= m;
        repeat (2) @(posedge aclk);
        src_event <= '0;
        #1;
        check(pending_out, m);
        check(missed_out, m & 32'h0000FFFF);
        rd(ipfs_pkg::ADDR_MISSED, m & 32'h0000FFFF, ipfs_pkg::RESP_OKAY);
        wr(ipfs_pkg::ADDR_MISSED, 32'h0, ipfs_pkg::RESP_OKAY);
        wr(ipfs_pkg::ADDR_PEND_CLEAR, m, ipfs_pkg::RESP_OKAY);
      end
    end
    wr(ipfs_pkg::ADDR_MISSED, 32'hFFFFFFFF, ipfs_pkg::RESP_OKAY);
    rd(ipfs_pkg::ADDR_MISSED, 32'h0000D7BC, ipfs_pkg::RESP_OKAY);
    // Byte strobes limit a write to the second byte
    s_axi_wstrb <= 4'h2;
    wr(ipfs_pkg::ADDR_MISSED, 32'h0, ipfs_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(ipfs_pkg::ADDR_MISSED, 32'h000000BC, ipfs_pkg::RESP_OKAY);
    wr(ipfs_pkg::ADDR_MISSED, 32'h0, ipfs_pkg::RESP_OKAY);
    rd(ipfs_pkg::ADDR_MISSED, 32'h0, ipfs_pkg::RESP_OKAY);
    // Core takes a source, slowly then promptly; the active register ignores writes
    for (int k = 0; k < 2; k++)
    begin
      m = (k == 0) ? 32'h00000100 : 32'h00000080;
      wr(ipfs_pkg::ADDR_PEND_SET, m, ipfs_pkg::RESP_OKAY);
      slow    <= (k == 0);
      take_en <= 1'b1;
      wait_active(m);
      take_en <= 1'b0;
      if (k == 0)
      begin
        wr(ipfs_pkg::ADDR_ACTIVE, 32'hFFFFFFFF, ipfs_pkg::RESP_OKAY);
        rd(ipfs_pkg::ADDR_ACTIVE, m, ipfs_pkg::RESP_OKAY);
      end
      wait_active(32'h0);
    end
    // Fault classes: byte, half, misaligned, privilege, above last register, above memory
    fault_case(mkf(ipfs_pkg::SIZE_BYTE, 2'h0, 5'h10), 32'h8);
    fault_case(mkf(ipfs_pkg::SIZE_HALF, 2'h0, 5'h10), 32'h8);
    fault_case(mkf(ipfs_pkg::SIZE_WORD, 2'h2, 5'h00), 32'h8);
    fault_case(mkf(ipfs_pkg::SIZE_WORD, 2'h0, 5'h0C), 32'h4);
    fault_case(mkf(ipfs_pkg::SIZE_WORD, 2'h0, 5'h12), 32'h2);
    fault_case(mkf(ipfs_pkg::SIZE_WORD, 2'h0, 5'h01), 32'h2);
    rd(ipfs_pkg::ADDR_AFSR, 32'h3, ipfs_pkg::RESP_OKAY);
    wr(ipfs_pkg::ADDR_AFSR, 32'hFFFFFFFF, ipfs_pkg::RESP_OKAY);
    rd(ipfs_pkg::ADDR_AFSR, 32'hF, ipfs_pkg::RESP_OKAY);
    // Second reset in mid-run with the status registers loaded
    wr(ipfs_pkg::ADDR_PEND_SET, 32'hFFFFFFFF, ipfs_pkg::RESP_OKAY);
    wr(ipfs_pkg::ADDR_MISSED, 32'hFFFFFFFF, ipfs_pkg::RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    check(pending_out, 32'h0);
    check(missed_out, 32'h0);
    check(fault_status_out, 32'h0);
    check({31'h0, hard_fault}, 32'h0);
    final_report();
  end
endmodule
